// ### logic/wwd_pkg.sv
// constants for the window watchdog: register map, field layout, service codes, timing
// assumes clk_sys at 100 MHz serves as the watchdog base clock
`default_nettype none
package wwd_pkg;
  // register offsets on the die-to-die register port
  localparam logic [7:0] WWD_CTL_OFS     = 8'h10;
  localparam logic [7:0] WWD_SVC_OFS     = 8'h11;
  // control register fields
  localparam int         WWD_OFF_BIT     = 7;
  localparam int         WWD_WO_BIT      = 6;
  localparam int         WWD_TMO_LSB     = 0;
  localparam int         WWD_TMO_W       = 3;
  localparam logic [2:0] WWD_TMO_RST     = 3'h0;
  localparam logic [7:0] WWD_SVC_RST     = 8'h00;
  localparam logic [7:0] WWD_RDATA_RST   = 8'h00;
  // service codes
  localparam logic [7:0] WWD_KEY_FIRST   = 8'haa;
  localparam logic [7:0] WWD_KEY_SECOND  = 8'h55;
  // timing
  localparam int         WWD_CLK_PERIOD_NS = 10;
  localparam int         WWD_TICK_NS       = 1000000;
  localparam int         WWD_CYC_PER_MS    = WWD_TICK_NS / WWD_CLK_PERIOD_NS;
  localparam int         WWD_TMO_BASE_MS   = 10;
  localparam int         WWD_INIT_TMO_MS   = 256;
  localparam int         WWD_MS_W          = 12;
  // watchdog phases
  typedef enum logic [0:0] {
    WWD_ST_INIT,
    WWD_ST_WIN
  } wwd_state_e;
endpackage : wwd_pkg
`default_nettype wire

// ### logic/wwd_pin_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin levels, one receiving clock
`default_nettype none
module wwd_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  wire  [W-1:0] out_d;

  // a bit moves only when stages two and three agree
  assign out_d   = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  assign pin_out = out_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= pin_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
endmodule : wwd_pin_sync
`default_nettype wire

// ### logic/wwd_top.sv
// window watchdog with its control and service registers
// assumes the register port is already synchronous to clk_sys, which is the base clock
`default_nettype none

// What this block does
// - the watchdog counts on the base clock only while the device is in normal mode.
// - the three-bit timeout field picks 10, 20, 40 ... 1280 ms, doubling per code.
// - after reset a fixed initial timeout runs with window open, and field writes leave it.
// - in the initial phase a timeout or any value other than 0xaa requests a reset.
// - in window mode a service in the first half of the period is refused.
// - in window mode a timeout or a wrong service value requests a reset.
// - control bit 6 reads set while the watchdog runs and the window is open.
// - the watchdog is fully disabled while the test voltage is present with test pin low.
// - control bit 7 reads set while the watchdog is disabled externally.
// - a read during low power shows the disabled flag set.
// - external disable clears the service register and forces the initial sequence again.
// - low power halts the counter and clears the service register.
// - service writes are ignored while disabled and a correct key in the window clears the count.
module wwd_top #(
  parameter int CYC_PER_MS  = wwd_pkg::WWD_CYC_PER_MS,
  parameter int INIT_TMO_MS = wwd_pkg::WWD_INIT_TMO_MS
) (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       normal_mode,
  input  wire logic       low_power,
  input  wire logic       test_voltage,
  input  wire logic       test_pin,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            wd_reset_req
);
  import wwd_pkg::*;

  localparam int PRE_W = $clog2(CYC_PER_MS + 1);

  function automatic logic [WWD_MS_W-1:0] wwd_tmo_ms(input logic [WWD_TMO_W-1:0] code);
    wwd_tmo_ms = WWD_MS_W'(WWD_TMO_BASE_MS) << code;
  endfunction : wwd_tmo_ms

  function automatic logic wwd_hit(input logic [7:0] addr, input logic [7:0] ofs);
    wwd_hit = (addr == ofs);
  endfunction : wwd_hit

  wwd_state_e              state_q;
  wwd_state_e              state_d;
  logic [PRE_W-1:0]        pre_q;
  logic [PRE_W-1:0]        pre_d;
  logic [WWD_MS_W-1:0]     ms_q;
  logic [WWD_MS_W-1:0]     ms_d;
  logic [7:0]              expect_q;
  logic [7:0]              expect_d;
  logic [7:0]              svc_q;
  logic [7:0]              svc_d;
  logic [WWD_TMO_W-1:0]    tmo_q;
  logic [WWD_TMO_W-1:0]    tmo_d;
  logic [7:0]              rdata_q;
  logic [7:0]              rdata_d;
  logic                    rst_q;
  logic [1:0]              pins_s;

  wire                     test_voltage_s;
  wire                     test_s;
  wire                     ext_dis;
  wire                     halt_clr;
  wire                     run;
  wire                     ctl_sel;
  wire                     svc_sel;
  wire                     ctl_wr;
  wire                     svc_wr;
  wire                     ms_tick;
  wire  [WWD_MS_W-1:0]     limit;
  wire  [WWD_MS_W-1:0]     half;
  wire                     expired;
  wire                     win_open;
  wire                     svc_ok;
  wire                     svc_bad;
  wire                     fault;
  wire                     off_flag;
  wire  [7:0]              ctl_rd;
  wire  [7:0]              rd_mux;

  wwd_pin_sync #(
    .W (2)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .pin_in  ({test_voltage, test_pin}),
    .pin_out (pins_s)
  );

  assign test_voltage_s   = pins_s[1];
  assign test_s   = pins_s[0];
  assign ext_dis  = test_voltage_s & ~test_s;
  assign halt_clr = ext_dis | low_power;
  assign run      = normal_mode & ~halt_clr;

  assign ctl_sel  = wwd_hit(reg_addr, WWD_CTL_OFS);
  assign svc_sel  = wwd_hit(reg_addr, WWD_SVC_OFS);
  assign ctl_wr   = reg_wr & ctl_sel;
  assign svc_wr   = reg_wr & svc_sel;

  // millisecond prescaler on the base clock
  assign ms_tick  = run & (pre_q == PRE_W'(CYC_PER_MS - 1));

  // initial phase ignores the timeout field
  assign limit    = (state_q == WWD_ST_INIT) ? WWD_MS_W'(INIT_TMO_MS)
                                             : wwd_tmo_ms(tmo_q);
  assign half     = limit >> 1;
  // at or past the limit, so a shortened field still trips on the next millisecond tick
  assign expired  = ms_tick & (ms_q >= limit - WWD_MS_W'(1));
  assign win_open = (state_q == WWD_ST_INIT) | (ms_q >= half);

  // service decode, ignored while disabled
  assign svc_ok   = run & svc_wr & win_open & (reg_wdata == expect_q);
  assign svc_bad  = run & svc_wr & ~svc_ok;
  assign fault    = svc_bad | (run & expired);

  assign off_flag = halt_clr;
  assign ctl_rd   = {off_flag, win_open & run, 3'h0, tmo_q};
  assign rd_mux   = ctl_sel ? ctl_rd :
                    svc_sel ? svc_q  : 8'h00;
  assign rdata_d  = reg_rd ? rd_mux : rdata_q;
  assign tmo_d    = ctl_wr ? reg_wdata[WWD_TMO_LSB +: WWD_TMO_W] : tmo_q;

  assign reg_rdata    = rdata_q;
  assign wd_reset_req = rst_q;

  always_comb begin
    state_d  = state_q;
    pre_d    = pre_q;
    ms_d     = ms_q;
    expect_d = expect_q;
    svc_d    = svc_q;
    if (halt_clr) begin
      // back to default, initial sequence needed again
      state_d  = WWD_ST_INIT;
      pre_d    = '0;
      ms_d     = '0;
      expect_d = WWD_KEY_FIRST;
      svc_d    = WWD_SVC_RST;
    end else if (run) begin
      if (fault) begin
        state_d  = WWD_ST_INIT;
        pre_d    = '0;
        ms_d     = '0;
        expect_d = WWD_KEY_FIRST;
        svc_d    = WWD_SVC_RST;
      end else if (svc_ok) begin
        // first 0xaa enters window mode, later keys alternate
        state_d  = WWD_ST_WIN;
        pre_d    = '0;
        ms_d     = '0;
        expect_d = (expect_q == WWD_KEY_FIRST) ? WWD_KEY_SECOND
                                               : WWD_KEY_FIRST;
        svc_d    = reg_wdata;
      end else if (ms_tick) begin
        pre_d    = '0;
        ms_d     = ms_q + WWD_MS_W'(1);
      end else begin
        pre_d    = pre_q + PRE_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q  <= WWD_ST_INIT;
      pre_q    <= '0;
      ms_q     <= '0;
      expect_q <= WWD_KEY_FIRST;
      svc_q    <= WWD_SVC_RST;
      tmo_q    <= WWD_TMO_RST;
      rdata_q  <= WWD_RDATA_RST;
      rst_q    <= 1'b0;
    end else begin
      state_q  <= state_d;
      pre_q    <= pre_d;
      ms_q     <= ms_d;
      expect_q <= expect_d;
      svc_q    <= svc_d;
      tmo_q    <= tmo_d;
      rdata_q  <= rdata_d;
      rst_q    <= fault;
    end
  end

  // checks
  chk_pulse_single_cycle: assert property (@(posedge clk_sys) disable iff (!resetn)
    wd_reset_req |=> !wd_reset_req && state_q == WWD_ST_INIT && ms_q == '0)
    else $error("reset request longer than one cycle or no restart");

  chk_wrong_key_trips: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && svc_wr && reg_wdata != expect_q) |=> wd_reset_req)
    else $error("wrong service value did not request reset");

  chk_init_needs_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_INIT && svc_wr && reg_wdata != WWD_KEY_FIRST)
    |=> wd_reset_req && state_q == WWD_ST_INIT)
    else $error("initial phase accepted a value other than the first key");

  chk_early_service: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_WIN && svc_wr && ms_q < half) |=> wd_reset_req)
    else $error("service in closed window was accepted");

  chk_first_key_enter: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_INIT && svc_wr && reg_wdata == WWD_KEY_FIRST)
    |=> state_q == WWD_ST_WIN && ms_q == '0 && expect_q == WWD_KEY_SECOND && !wd_reset_req)
    else $error("first key did not start window mode");

  chk_key_alternates: assert property (@(posedge clk_sys) disable iff (!resetn)
    (svc_ok && state_q == WWD_ST_WIN) |=> expect_q == ~$past(expect_q) && ms_q == '0)
    else $error("service keys do not alternate");

  chk_init_limit_fixed: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == WWD_ST_INIT) |-> limit == WWD_MS_W'(INIT_TMO_MS) && win_open)
    else $error("initial timeout follows the field or window closed");

  chk_timeout_trips: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_WIN && ms_tick && ms_q == wwd_tmo_ms(tmo_q) - WWD_MS_W'(1))
    |=> wd_reset_req)
    else $error("window timeout did not request reset");

  chk_disable_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
    ext_dis |=> state_q == WWD_ST_INIT && svc_q == WWD_SVC_RST && !wd_reset_req)
    else $error("external disable did not restore defaults");

  chk_low_power_halt: assert property (@(posedge clk_sys) disable iff (!resetn)
    low_power[*2] |-> pre_q == '0 && ms_q == '0 && svc_q == WWD_SVC_RST)
    else $error("counter runs in low power");

  chk_stop_read_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && low_power && reg_addr == WWD_CTL_OFS) |=> reg_rdata[WWD_OFF_BIT])
    else $error("low power read shows watchdog enabled");

  chk_halted_no_trip: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!run) |=> !wd_reset_req)
    else $error("reset request while watchdog halted");

  chk_init_expiry: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_INIT && ms_tick && ms_q == WWD_MS_W'(INIT_TMO_MS - 1))
    |=> wd_reset_req && state_q == WWD_ST_INIT)
    else $error("initial timeout did not request reset");

  chk_expect_init_first: assert property (@(posedge clk_sys) disable iff (!resetn)
    (state_q == WWD_ST_INIT) |-> expect_q == WWD_KEY_FIRST)
    else $error("initial phase expects a key other than the first");

  chk_open_window_accepts: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && state_q == WWD_ST_WIN && svc_wr && ms_q >= half && !expired
     && reg_wdata == expect_q)
    |=> !wd_reset_req && state_q == WWD_ST_WIN && ms_q == '0 && svc_q == $past(reg_wdata))
    else $error("correct key in open window was refused");

  chk_no_spurious_req: assert property (@(posedge clk_sys) disable iff (!resetn)
    (run && !svc_wr && !(ms_tick && ms_q >= limit - WWD_MS_W'(1))) |=> !wd_reset_req)
    else $error("reset request without timeout or service write");

  chk_wo_init_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && ctl_sel && run && state_q == WWD_ST_INIT) |=> reg_rdata[WWD_WO_BIT])
    else $error("window flag reads closed in initial phase");

  chk_wo_closed_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && ctl_sel && run && state_q == WWD_ST_WIN && ms_q < half)
    |=> !reg_rdata[WWD_WO_BIT])
    else $error("window flag reads open in first half");

  chk_off_ext_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && ctl_sel && ext_dis) |=> reg_rdata[WWD_OFF_BIT])
    else $error("disabled flag clear while disabled externally");

  chk_off_clear_read: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && ctl_sel && !halt_clr) |=> !reg_rdata[WWD_OFF_BIT])
    else $error("disabled flag set while watchdog enabled");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && ctl_sel) |=> reg_rdata[WWD_WO_BIT-1:WWD_TMO_W] == 3'h0)
    else $error("reserved control bits read nonzero");

  chk_svc_read_data: assert property (@(posedge clk_sys) disable iff (!resetn)
    (reg_rd && svc_sel) |=> reg_rdata == $past(svc_q))
    else $error("service read does not return the last key");

  chk_field_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!ctl_wr) |=> $stable(tmo_q))
    else $error("timeout field changed without a write");

  chk_svc_ignored_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    (halt_clr && svc_wr) |=> svc_q == WWD_SVC_RST && !wd_reset_req)
    else $error("service write acted while disabled");

  chk_svc_keeps: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!svc_ok && !halt_clr && !fault) |=> $stable(svc_q))
    else $error("service register changed without accepted key");

  chk_normal_freeze: assert property (@(posedge clk_sys) disable iff (!resetn)
    (!normal_mode && !halt_clr) |=> $stable(ms_q) && $stable(state_q))
    else $error("watchdog counts outside normal mode");

  chk_disable_no_count: assert property (@(posedge clk_sys) disable iff (!resetn)
    ext_dis |=> pre_q == '0 && ms_q == '0)
    else $error("counter runs while disabled externally");

  chk_prescale_range: assert property (@(posedge clk_sys) disable iff (!resetn)
    pre_q < PRE_W'(CYC_PER_MS))
    else $error("millisecond prescaler out of range");
endmodule : wwd_top
`default_nettype wire

// ### testbench/wwd_mcu_model.sv
// register master model of the controlling die on the watchdog port
// assumes the bench calls acc after reset and clk_sys is running
`default_nettype none
module wwd_mcu_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle strobe, then idle lines show the inverse of the last value
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr    = wr;
    reg_rd    = !wr;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : acc
endmodule : wwd_mcu_model
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for wwd_top with shortened timing
// assumes wwd_mcu_model drives the register port
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import wwd_pkg::*;
  localparam int CPM = 4;
  localparam int ITO = 8;
  logic       clk_sys, resetn, normal_mode, low_power, test_voltage, test_pin;
  logic       reg_wr, reg_rd, wd_reset_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  int         n_fail, total_checks, seed, hi_run, n, cyc, t0;
  wwd_top #(.CYC_PER_MS(CPM), .INIT_TMO_MS(ITO)) i_wwd_top (
    .clk_sys(clk_sys), .resetn(resetn), .normal_mode(normal_mode),
    .low_power(low_power), .test_voltage(test_voltage), .test_pin(test_pin),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .wd_reset_req(wd_reset_req));
  wwd_mcu_model i_wwd_mcu_model (
    .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  function automatic logic [7:0] ctl(logic off, logic wo, logic [2:0] c);
    return {off, wo, 3'h0, c};
  endfunction : ctl
  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk_reg
  task automatic chk_req(input logic e, input logic g);
    chk_reg({7'h0, e}, {7'h0, g});
  endtask : chk_req
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wwd_mcu_model.acc(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_wwd_mcu_model.acc(1'b0, a, 8'($random(seed)));
    chk_reg(e, reg_rdata);
  endtask : rd_chk
  task automatic bad(input logic [7:0] d);
    wr(WWD_SVC_OFS, d);
    chk_req(1'b1, wd_reset_req);
    @(negedge clk_sys);
    chk_req(1'b0, wd_reset_req);
  endtask : bad
  task automatic wait_req(input int mx);
    n = 0;
    while (wd_reset_req !== 1'b1 && n < mx) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_req
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    cyc++;
    hi_run = (wd_reset_req === 1'b1) ? hi_run + 1 : 0;
    if (hi_run == 2) chk_req(1'b0, 1'b1);
  end
  initial begin
    #400us;
    n_fail++;
    end_sim();
  end
  initial begin
    {n_fail, total_checks, hi_run, cyc} = '0;
    seed = 23097;
    {resetn, low_power, test_voltage} = 3'b000;
    {normal_mode, test_pin} = 2'b11;
    repeat (16) @(negedge clk_sys);
    resetn = 1'b1;
    t0 = cyc;
    rd_chk(WWD_CTL_OFS, 8'h40);
    repeat (3) begin
      v = 8'($random(seed)) | 8'h04;
      wr(WWD_CTL_OFS, v);
      rd_chk(WWD_CTL_OFS, ctl(1'b0, 1'b1, v[2:0]));
    end
    wait_req(40);
    chk_req(1'b1, (cyc - t0) inside {[ITO*CPM-3 : ITO*CPM+4]});
    v = 8'($random(seed));
    if (v == WWD_KEY_FIRST) v = 8'h11;
    bad(v);
    wr(WWD_CTL_OFS, 8'h00);
    wr(WWD_SVC_OFS, WWD_KEY_FIRST);
    rd_chk(WWD_CTL_OFS, 8'h00);
    bad(WWD_KEY_SECOND);
    wr(WWD_SVC_OFS, WWD_KEY_FIRST);
    repeat (26) @(negedge clk_sys);
    rd_chk(WWD_CTL_OFS, 8'h40);
    wr(WWD_SVC_OFS, WWD_KEY_SECOND);
    rd_chk(WWD_SVC_OFS, WWD_KEY_SECOND);
    repeat (26) @(negedge clk_sys);
    wr(WWD_SVC_OFS, WWD_KEY_FIRST);
    rd_chk(WWD_SVC_OFS, WWD_KEY_FIRST);
    repeat (26) @(negedge clk_sys);
    bad(WWD_KEY_FIRST);
    for (int c = 0; c < 8; c++) begin
      wr(WWD_CTL_OFS, 8'(c));
      wr(WWD_SVC_OFS, WWD_KEY_FIRST);
      wait_req((10 << c) * CPM + 20);
      chk_req(1'b1, n inside {[(10 << c) * CPM - 6 : (10 << c) * CPM + 6]});
      @(negedge clk_sys);
    end
    test_pin = 1'b0;
    test_voltage = 1'b1;
    repeat (8) @(negedge clk_sys);
    rd_chk(WWD_CTL_OFS, ctl(1'b1, 1'b0, 3'h7));
    wr(WWD_SVC_OFS, WWD_KEY_FIRST);
    rd_chk(WWD_SVC_OFS, WWD_SVC_RST);
    wait_req(60);
    chk_req(1'b0, wd_reset_req);
    test_voltage = 1'b0;
    repeat (8) @(negedge clk_sys);
    bad(WWD_KEY_SECOND);
    wr(WWD_SVC_OFS, WWD_KEY_FIRST);
    low_power = 1'b1;
    rd_chk(WWD_CTL_OFS, ctl(1'b1, 1'b0, 3'h7));
    rd_chk(WWD_SVC_OFS, WWD_SVC_RST);
    wait_req(60);
    chk_req(1'b0, wd_reset_req);
    low_power = 1'b0;
    normal_mode = 1'b0;
    wait_req(60);
    chk_req(1'b0, wd_reset_req);
    normal_mode = 1'b1;
    resetn = 1'b0;
    repeat (4) @(negedge clk_sys);
    resetn = 1'b1;
    rd_chk(WWD_CTL_OFS, ctl(1'b0, 1'b1, WWD_TMO_RST));
    v = 8'($random(seed)) | 8'h20;
    wr(v, 8'h07);
    rd_chk(WWD_CTL_OFS, ctl(1'b0, 1'b1, WWD_TMO_RST));
    rd_chk(v, 8'h00);
    bad(WWD_KEY_SECOND);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
